//--- design/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;
  // Overview of operation
  // - raw comparator result is high when positive input exceeds negative input.
  // - raw result passes a two-flop synchroniser before showing as output status bit.
  // - control register bits: 5 output, 4 flag, 3 irq enable, 2 route, 1:0 mode.
  // - hardware sets the event flag when the selected output event occurs.
  // - interrupt asserted only on the clock after flag, irq enable and global enable were all set.
  // - flag clears automatically when the processor vectors to the comparator handler.
  // - writing one to the flag clears it; writing zero leaves it alone.
  // - irq enable at zero blocks the comparator interrupt whatever the flag.
  // - route enable high feeds comparator output to the timer capture front end.
  // - route enable low leaves the timer capture input with no comparator connection.
  // - mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
  // - mux enable with converter off selects converter pin 0..7 as negative input.
  // - mux enable clear or converter enabled selects the dedicated negative pin.
  // - disable bit powers the comparator down; software drops irq enable first.
  // - bandgap select replaces the positive input by a fixed internal reference.

  localparam int VOLT_W = 10;
  localparam int NUM_MUX_PINS = 8;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CSR_W = 8;
  localparam int MUX_W = 5;

  localparam logic [ADR_W-1:0] OFF_CSR = 8'h00;
  localparam logic [ADR_W-1:0] OFF_MUX = 8'h04;
  localparam logic [ADR_W-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [ADR_W-1:0] OFF_IRQ_MASK = 8'h0C;

  localparam int IRQ_BIT_EVENT = 0;

  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;

  typedef logic [VOLT_W-1:0] volt_t;

  // internal reference level in input code units
  localparam volt_t BANDGAP_LEVEL = 10'h200;

  typedef struct packed {
    logic cmp_disable;
    logic cmp_bandgap_select;
    logic cmp_out_sync;
    logic cmp_event_flag;
    logic cmp_irq_enable;
    logic cmp_capture_route_en;
    logic [1:0] cmp_event_mode;
  } csr_s;

  typedef struct packed {
    logic [2:0] channel_select_low;
    logic converter_enable;
    logic cmp_neg_mux_en;
  } mux_s;

  localparam csr_s CSR_RESET = 8'h00;
  localparam mux_s MUX_RESET = 5'h00;
endpackage : cmp_ctrl_pkg

//--- design/comparator_event_control.sv
// Chosen here: the address map and the Wishbone interface to the registers.
module comparator_event_control
  import cmp_ctrl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [ADR_W-1:0] ADR_I,
  input wire logic [DAT_W-1:0] DAT_I,
  output logic [DAT_W-1:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  input wire volt_t CMP_POS_PIN,
  input wire volt_t CMP_NEG_PIN,
  input wire volt_t [NUM_MUX_PINS-1:0] CONVERTER_INPUT_PINS,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic IRQ_VECTOR_ACK,
  output logic IRQ,
  output logic CMP_OUT,
  output logic CMP_POWER_DOWN,
  output logic CAPTURE_CMP
);

  function automatic logic addr_is(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] off);
    addr_is = (adr == off);
  endfunction : addr_is

  // control state
  logic cmp_disable;
  logic cmp_bandgap_select;
  logic cmp_event_flag;
  logic cmp_irq_enable;
  logic cmp_capture_route_en;
  logic [1:0] cmp_event_mode;
  mux_s mux_cfg;

  // synchroniser and event history
  logic sync_meta;
  logic cmp_out_sync;
  logic out_prev;

  // bus decode
  wire req = CYC_I & STB_I;
  wire wr_take = req & WE_I & ACK_O & SEL_I[0];
  wire wr_csr = wr_take & addr_is(ADR_I, OFF_CSR);
  wire wr_mux = wr_take & addr_is(ADR_I, OFF_MUX);
  wire wr_stat = wr_take & addr_is(ADR_I, OFF_IRQ_STAT);
  wire wr_mask = wr_take & addr_is(ADR_I, OFF_IRQ_MASK);
  wire csr_s wr_csr_val = csr_s'(DAT_I[CSR_W-1:0]);
  wire mux_s wr_mux_val = mux_s'(DAT_I[MUX_W-1:0]);

  // analog front end, modelled on input codes
  wire use_mux = mux_cfg.cmp_neg_mux_en & ~mux_cfg.converter_enable;
  wire volt_t mux_pin = CONVERTER_INPUT_PINS[mux_cfg.channel_select_low];
  wire volt_t neg_in = use_mux ? mux_pin : CMP_NEG_PIN;
  wire volt_t pos_in = cmp_bandgap_select ? BANDGAP_LEVEL : CMP_POS_PIN;
  // powered-down comparator reads low
  wire raw_result = ~cmp_disable & (pos_in > neg_in);

  // edge detection on the synchronised output
  wire rise = cmp_out_sync & ~out_prev;
  wire fall = ~cmp_out_sync & out_prev;
  wire event_hit = (cmp_event_mode == MODE_TOGGLE) ? (rise | fall) :
                   (cmp_event_mode == MODE_FALL) ? fall :
                   (cmp_event_mode == MODE_RISE) ? rise :
                   1'b0;

  // flag clears: vector taken or a one written to either view of the flag
  wire w1c_flag = (wr_csr & wr_csr_val.cmp_event_flag) |
                  (wr_stat & DAT_I[IRQ_BIT_EVENT]);
  wire flag_clear = IRQ_VECTOR_ACK | w1c_flag;
  // a new event beats a clear in the same cycle
  wire next_flag = event_hit | (cmp_event_flag & ~flag_clear);

  wire next_irq = cmp_event_flag & cmp_irq_enable & GLOBAL_IRQ_EN;
  // route off holds the capture input low, not merely gated later
  wire next_capture = cmp_capture_route_en & cmp_out_sync;

  wire csr_s csr_view = '{
    cmp_disable: cmp_disable,
    cmp_bandgap_select: cmp_bandgap_select,
    cmp_out_sync: cmp_out_sync,
    cmp_event_flag: cmp_event_flag,
    cmp_irq_enable: cmp_irq_enable,
    cmp_capture_route_en: cmp_capture_route_en,
    cmp_event_mode: cmp_event_mode
  };

  wire logic [DAT_W-1:0] rd_word =
    addr_is(ADR_I, OFF_CSR) ? {{(DAT_W-CSR_W){1'b0}}, csr_view} :
    addr_is(ADR_I, OFF_MUX) ? {{(DAT_W-MUX_W){1'b0}}, mux_cfg} :
    addr_is(ADR_I, OFF_IRQ_STAT) ? {{(DAT_W-1){1'b0}}, cmp_event_flag} :
    addr_is(ADR_I, OFF_IRQ_MASK) ? {{(DAT_W-1){1'b0}}, cmp_irq_enable} :
    '0;

  wire next_ack = req & ~ACK_O;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else if (CE) begin
      ACK_O <= next_ack;
      DAT_O <= next_ack ? rd_word : '0;
    end
  end

  // two-flop synchroniser; the meta stage feeds only the next stage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_meta <= 1'b0;
      cmp_out_sync <= 1'b0;
      out_prev <= 1'b0;
    end else if (CE) begin
      sync_meta <= raw_result;
      cmp_out_sync <= sync_meta;
      out_prev <= cmp_out_sync;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_disable <= CSR_RESET.cmp_disable;
      cmp_bandgap_select <= CSR_RESET.cmp_bandgap_select;
      cmp_capture_route_en <= CSR_RESET.cmp_capture_route_en;
      cmp_event_mode <= CSR_RESET.cmp_event_mode;
    end else if (CE && wr_csr) begin
      // mode change with irq enabled may flag a spurious event
      cmp_disable <= wr_csr_val.cmp_disable;
      cmp_bandgap_select <= wr_csr_val.cmp_bandgap_select;
      cmp_capture_route_en <= wr_csr_val.cmp_capture_route_en;
      cmp_event_mode <= wr_csr_val.cmp_event_mode;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_irq_enable <= CSR_RESET.cmp_irq_enable;
    end else if (CE && wr_csr) begin
      cmp_irq_enable <= wr_csr_val.cmp_irq_enable;
    end else if (CE && wr_mask) begin
      cmp_irq_enable <= DAT_I[IRQ_BIT_EVENT];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mux_cfg <= MUX_RESET;
    end else if (CE && wr_mux) begin
      mux_cfg <= wr_mux_val;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_event_flag <= CSR_RESET.cmp_event_flag;
      IRQ <= 1'b0;
      CAPTURE_CMP <= 1'b0;
    end else if (CE) begin
      cmp_event_flag <= next_flag;
      IRQ <= next_irq;
      CAPTURE_CMP <= next_capture;
    end
  end

  assign CMP_OUT = cmp_out_sync;
  assign CMP_POWER_DOWN = cmp_disable;

  // checks

  property p_sync_delay;
    @(posedge CLK) disable iff (!RST_N)
      CE ##1 CE |=> (cmp_out_sync == $past(raw_result, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("output status does not follow raw result after two clocks");

  property p_raw_compare;
    @(posedge CLK) disable iff (!RST_N)
      (!cmp_disable && !cmp_bandgap_select && !mux_cfg.cmp_neg_mux_en) |->
        (raw_result == (CMP_POS_PIN > CMP_NEG_PIN));
  endproperty
  a_raw_compare: assert property (p_raw_compare)
    else $error("raw result disagrees with input comparison");

  property p_flag_set;
    @(posedge CLK) disable iff (!RST_N)
      (CE && event_hit) |=> cmp_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set the flag");

  property p_flag_w1c;
    @(posedge CLK) disable iff (!RST_N)
      (CE && wr_csr && wr_csr_val.cmp_event_flag && !event_hit) |=> !cmp_event_flag;
  endproperty
  a_flag_w1c: assert property (p_flag_w1c)
    else $error("writing one did not clear the flag");

  property p_flag_w0_keeps;
    @(posedge CLK) disable iff (!RST_N)
      (CE && cmp_event_flag && !flag_clear) |=> cmp_event_flag;
  endproperty
  a_flag_w0_keeps: assert property (p_flag_w0_keeps)
    else $error("flag lost without a clear");

  property p_vector_clear;
    @(posedge CLK) disable iff (!RST_N)
      (CE && IRQ_VECTOR_ACK && !event_hit) |=> !cmp_event_flag;
  endproperty
  a_vector_clear: assert property (p_vector_clear)
    else $error("vector did not clear the flag");

  property p_irq_level;
    @(posedge CLK) disable iff (!RST_N)
      CE |=> (IRQ == $past(cmp_event_flag && cmp_irq_enable && GLOBAL_IRQ_EN));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not match flag, enable and global enable");

  property p_irq_blocked;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !cmp_irq_enable) |=> !IRQ;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("interrupt raised with enable clear");

  property p_capture_off;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !cmp_capture_route_en) |=> !CAPTURE_CMP;
  endproperty
  a_capture_off: assert property (p_capture_off)
    else $error("capture input driven with routing off");

  property p_capture_on;
    @(posedge CLK) disable iff (!RST_N)
      (CE && cmp_capture_route_en) |=> (CAPTURE_CMP == $past(cmp_out_sync));
  endproperty
  a_capture_on: assert property (p_capture_on)
    else $error("capture input does not follow comparator output");

  property p_reserved_mode;
    @(posedge CLK) disable iff (!RST_N)
      (cmp_event_mode == MODE_RESERVED) |-> !event_hit;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("reserved mode produced an event");

  property p_rise_mode;
    @(posedge CLK) disable iff (!RST_N)
      ($past(CE) && cmp_event_mode == MODE_RISE) |-> (event_hit == $rose(cmp_out_sync));
  endproperty
  a_rise_mode: assert property (p_rise_mode)
    else $error("rising mode decode wrong");

  property p_neg_select;
    @(posedge CLK) disable iff (!RST_N)
      (!mux_cfg.cmp_neg_mux_en || mux_cfg.converter_enable) |-> (neg_in == CMP_NEG_PIN);
  endproperty
  a_neg_select: assert property (p_neg_select)
    else $error("dedicated negative pin not selected");

  property p_mux_select;
    @(posedge CLK) disable iff (!RST_N)
      (mux_cfg.cmp_neg_mux_en && !mux_cfg.converter_enable) |->
        (neg_in == CONVERTER_INPUT_PINS[mux_cfg.channel_select_low]);
  endproperty
  a_mux_select: assert property (p_mux_select)
    else $error("converter pin not selected as negative input");

  property p_status_bit;
    @(posedge CLK) disable iff (!RST_N)
      (CE && req && !WE_I && !ACK_O && addr_is(ADR_I, OFF_CSR)) |=>
        (ACK_O && DAT_O[5] == $past(cmp_out_sync) && DAT_O[4] == $past(cmp_event_flag));
  endproperty
  a_status_bit: assert property (p_status_bit)
    else $error("control register read shows wrong status bits");

  property p_disable_low;
    @(posedge CLK) disable iff (!RST_N)
      cmp_disable |-> !raw_result;
  endproperty
  a_disable_low: assert property (p_disable_low)
    else $error("powered-down comparator reports a high result");

  property p_fall_mode;
    @(posedge CLK) disable iff (!RST_N)
      ($past(CE) && cmp_event_mode == MODE_FALL) |-> (event_hit == $fell(cmp_out_sync));
  endproperty
  a_fall_mode: assert property (p_fall_mode)
    else $error("falling mode decode wrong");

  property p_toggle_mode;
    @(posedge CLK) disable iff (!RST_N)
      ($past(CE) && cmp_event_mode == MODE_TOGGLE) |-> (event_hit == $changed(cmp_out_sync));
  endproperty
  a_toggle_mode: assert property (p_toggle_mode)
    else $error("toggle mode decode wrong");

  property p_irq_needs_flag;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !cmp_event_flag) |=> !IRQ;
  endproperty
  a_irq_needs_flag: assert property (p_irq_needs_flag)
    else $error("interrupt raised with the flag clear");

  property p_irq_needs_gie;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !GLOBAL_IRQ_EN) |=> !IRQ;
  endproperty
  a_irq_needs_gie: assert property (p_irq_needs_gie)
    else $error("interrupt raised with global enable off");

  property p_flag_only_event;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !cmp_event_flag && !event_hit) |=> !cmp_event_flag;
  endproperty
  a_flag_only_event: assert property (p_flag_only_event)
    else $error("flag set without an event");

  property p_mode_write;
    @(posedge CLK) disable iff (!RST_N)
      (CE && wr_csr) |=> (cmp_event_mode == $past(wr_csr_val.cmp_event_mode));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode bits not taken from control write");

  property p_ctrl_read;
    @(posedge CLK) disable iff (!RST_N)
      (CE && req && !WE_I && !ACK_O && addr_is(ADR_I, OFF_CSR)) |=>
        (DAT_O[7:6] == $past({cmp_disable, cmp_bandgap_select}) &&
         DAT_O[3:0] == $past({cmp_irq_enable, cmp_capture_route_en, cmp_event_mode}));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register read shows wrong control bits");

  property p_freeze;
    @(posedge CLK) disable iff (!RST_N)
      !CE |=> ($stable(cmp_out_sync) && $stable(cmp_event_flag) && $stable(IRQ));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable was low");

endmodule : comparator_event_control

//--- bench/cpu_side_model.sv
module cpu_side_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq,
  input wire logic take_irq,
  input wire logic capture_in,
  input wire logic capture_irq_en,
  output logic vector_ack,
  output int capture_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic capture_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_ack <= 1'b0;
      capture_prev <= 1'b0;
      capture_count <= 0;
    end else begin
      // one-cycle vector; irq lags the flag clear, so a held request vectors once more after the gap cycle
      vector_ack <= take_irq && irq && !vector_ack;
      capture_prev <= capture_in;
      // timer edge select on rising edges, counted only with its irq enabled
      if (capture_irq_en && capture_in && !capture_prev) begin
        capture_count <= capture_count + 1;
      end
    end
  end
endmodule : cpu_side_model

//--- bench/comparator_event_control_test.sv
module comparator_event_control_test;
  import cmp_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_N, cyc, stb, we, gie, take, ack, irq, out, pdn, cap, vec, ce, cie;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] dat, rdat, rd;
  volt_t pos, neg;
  volt_t [NUM_MUX_PINS-1:0] pins;
  int n_errors, cmp_count, cycles, caps, k;

  comparator_event_control comparator_event_control_inst (.CLK(CLK), .RST_N(RST_N), .CE(ce),
    .ADR_I(adr), .DAT_I(dat), .DAT_O(rdat), .WE_I(we), .SEL_I(4'hF), .CYC_I(cyc), .STB_I(stb),
    .ACK_O(ack), .CMP_POS_PIN(pos), .CMP_NEG_PIN(neg), .CONVERTER_INPUT_PINS(pins),
    .GLOBAL_IRQ_EN(gie), .IRQ_VECTOR_ACK(vec), .IRQ(irq), .CMP_OUT(out),
    .CMP_POWER_DOWN(pdn), .CAPTURE_CMP(cap));
  cpu_side_model cpu_side_model_inst (.clk(CLK), .rst_n(RST_N), .irq(irq), .take_irq(take),
    .capture_in(cap), .capture_irq_en(cie), .vector_ack(vec), .capture_count(caps));

  task automatic finish_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // pre-edge values are sampled, so ack and read data are taken at one edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dat <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      finish_test();
    end
  endtask : wb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk

  // six edges covers sync, flag and the registered irq
  task automatic set_cmp(input logic v);
    @(posedge CLK);
    pos <= v ? 10'h300 : 10'h100;
    repeat (6) @(posedge CLK);
  endtask : set_cmp

  task automatic t_reset;
    rdchk("csr", OFF_CSR, 32'h0);
    rdchk("mux", OFF_MUX, 32'h0);
    wb(8'h10, 1'b1, 32'hFF);
    rdchk("unmapped", 8'h10, 32'h0);
  endtask : t_reset

  task automatic t_toggle;
    set_cmp(1'b1);
    chk("out", out, 1'b1);
    rdchk("csr", OFF_CSR, 32'h30);
    chk("irq_off", irq, 1'b0);
    wb(OFF_IRQ_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge CLK);
    chk("irq_on", irq, 1'b1);
    gie <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("irq_gie", irq, 1'b0);
    gie <= 1'b1;
    wb(OFF_CSR, 1'b1, 32'h08);
    rdchk("w0", OFF_CSR, 32'h38);
    rdchk("stat", OFF_IRQ_STAT, 32'h1);
    rdchk("mask", OFF_IRQ_MASK, 32'h1);
    wb(OFF_IRQ_STAT, 1'b1, 32'h1);
    rdchk("w1c", OFF_CSR, 32'h28);
    chk("irq_clr", irq, 1'b0);
    wb(OFF_CSR, 1'b1, 32'h00);
  endtask : t_toggle

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      set_cmp(1'b0);
      wb(OFF_CSR, 1'b1, 32'h10 | m);
      set_cmp(1'b1);
      rdchk("rise", OFF_CSR, 32'h20 | m | ((m == 0 || m == 3) ? 32'h10 : 32'h0));
      wb(OFF_CSR, 1'b1, 32'h10 | m);
      set_cmp(1'b0);
      rdchk("fall", OFF_CSR, m | ((m == 0 || m == 2) ? 32'h10 : 32'h0));
    end
  endtask : t_modes

  task automatic t_vector;
    wb(OFF_CSR, 1'b1, 32'h1B);
    take <= 1'b1;
    set_cmp(1'b1);
    repeat (3) @(posedge CLK);
    take <= 1'b0;
    rdchk("vector", OFF_CSR, 32'h2B);
    chk("irq_vec", irq, 1'b0);
  endtask : t_vector

  task automatic t_route;
    wb(OFF_CSR, 1'b1, 32'h04);
    // capture output lags the write by one register stage
    repeat (3) @(posedge CLK);
    chk("cap_on", cap, 1'b1);
    k = caps;
    set_cmp(1'b0);
    chk("cap_lo", cap, 1'b0);
    set_cmp(1'b1);
    chk("cap_edge", caps, k + 1);
    cie <= 1'b0;
    set_cmp(1'b0);
    set_cmp(1'b1);
    chk("cap_masked", caps, k + 1);
    cie <= 1'b1;
    wb(OFF_CSR, 1'b1, 32'h00);
    repeat (2) @(posedge CLK);
    chk("cap_off", cap, 1'b0);
  endtask : t_route

  task automatic t_ce;
    ce <= 1'b0;
    set_cmp(1'b0);
    chk("ce_hold", out, 1'b1);
    ce <= 1'b1;
    repeat (4) @(posedge CLK);
    chk("ce_run", out, 1'b0);
  endtask : t_ce

  task automatic t_mux;
    pos <= 10'h200;
    for (int i = 0; i < NUM_MUX_PINS; i++) begin
      for (int j = 0; j < NUM_MUX_PINS; j++) pins[j] <= (i == j) ? 10'h100 : 10'h300;
      wb(OFF_MUX, 1'b1, (i << 2) | 1);
      repeat (4) @(posedge CLK);
      chk("mux_pin", out, 1'b1);
      wb(OFF_MUX, 1'b1, (i << 2) | 3);
      repeat (4) @(posedge CLK);
      chk("mux_converter_enable", out, 1'b0);
    end
    wb(OFF_MUX, 1'b1, 32'h1C);
    repeat (4) @(posedge CLK);
    chk("mux_off", out, 1'b0);
  endtask : t_mux

  task automatic t_bg;
    pos <= 10'h100;
    neg <= 10'h1FF;
    wb(OFF_CSR, 1'b1, 32'h40);
    repeat (4) @(posedge CLK);
    chk("bandgap", out, 1'b1);
    // bandgap kept on so only the disable can pull the result low
    wb(OFF_CSR, 1'b1, 32'hC0);
    repeat (4) @(posedge CLK);
    chk("pdn", pdn, 1'b1);
    chk("pdn_out", out, 1'b0);
  endtask : t_bg

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {RST_N, cyc, stb, we, take, adr, dat} = '0;
    gie = 1'b1;
    ce = 1'b1;
    cie = 1'b1;
    pos = 10'h100;
    neg = 10'h200;
    pins = '0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_toggle();
    t_modes();
    t_vector();
    t_route();
    t_ce();
    t_mux();
    t_bg();
    finish_test();
  end
endmodule : comparator_event_control_test
